/* File: rtl/cat_pkg.sv */
// constants for the channel-access timing core
// assumes a 100 MHz clock and a 32.768 kHz slow-clock rate made by division
package cat_pkg;
  localparam int NUM_AC = 4;
  localparam int BO_W = 10;
  localparam int NAV_W = 16;
  localparam int TSF_W = 64;
  localparam int SLEEP_W = 32;
  localparam int CYC_W = 12;
  localparam int NUM_EVT = 2;
  // times in ns, as the protocol gives them
  localparam int CLK_NS = 10;
  localparam int US_NS = 1000;
  localparam int SIFS_NS = 10000;
  localparam int RIFS_NS = 2000;
  localparam int SLOT_NS = 9000;
  localparam int SLOW_NS = 30518;
  // cycle counts, least times rounded up
  localparam logic [CYC_W-1:0] US_CNT = CYC_W'((US_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CYC_W-1:0] SIFS_CNT =
    CYC_W'((SIFS_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CYC_W-1:0] RIFS_CNT =
    CYC_W'((RIFS_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CYC_W-1:0] SLOT_CNT =
    CYC_W'((SLOT_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CYC_W-1:0] SLOW_CNT =
    CYC_W'((SLOW_NS + CLK_NS - 1) / CLK_NS);
  // reset values
  localparam logic [CYC_W-1:0] CYC_RST = 12'h000;
  localparam logic [TSF_W-1:0] TSF_RST = 64'h0000_0000_0000_0000;
  typedef enum logic {PRIO_HIGH_FIRST = 1'b0, PRIO_LOW_FIRST = 1'b1} cat_prio_t;
  typedef enum logic [1:0] {
    SLP_AWAKE = 2'b00,
    SLP_ASLEEP = 2'b01,
    SLP_WAKE = 2'b10
  } cat_slp_t;
endpackage

/* File: rtl/cat_backoff.sv */
// one back-off engine for a single access category
// assumes slot_tick_in pulses once per slot and busy_in merges phy and nav
`timescale 1ns/10ps
module cat_backoff (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic run_in,
  input wire logic load_in,
  input wire logic [cat_pkg::BO_W-1:0] load_val_in,
  input wire logic slot_tick_in,
  input wire logic busy_in,
  output logic zero_out,
  output logic done_out
);
  logic [cat_pkg::BO_W-1:0] cnt_r;
  logic [cat_pkg::BO_W-1:0] cnt_nxt;
  logic armed_r;
  logic armed_nxt;
  logic done_r;
  logic done_nxt;

  // busy slots hold the count instead of losing progress
  always_comb begin
    cnt_nxt = cnt_r;
    armed_nxt = armed_r;
    done_nxt = 1'b0;
    if (run_in) begin
      if (load_in) begin
        cnt_nxt = load_val_in;
        armed_nxt = 1'b1;
      end else if (slot_tick_in && !busy_in && armed_r) begin
        if (cnt_r <= cat_pkg::BO_W'(1)) begin
          cnt_nxt = '0;
          armed_nxt = 1'b0;
          done_nxt = 1'b1;
        end else begin
          cnt_nxt = cnt_r - cat_pkg::BO_W'(1);
        end
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      cnt_r <= '0;
      armed_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      armed_r <= armed_nxt;
      done_r <= done_nxt;
    end
  end

  assign zero_out = (cnt_r == '0);
  assign done_out = done_r;

  bo_pause_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (busy_in && !load_in) |=> $stable(cnt_r))
    else $error("back-off count moved while medium busy");
  bo_done_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (run_in && !load_in && slot_tick_in && !busy_in && armed_r &&
     cnt_r == cat_pkg::BO_W'(1)) |=> (done_r && cnt_r == '0))
    else $error("back-off expiry not signalled");
endmodule // cat_backoff

/* File: rtl/cat_timing.sv */
// channel-access timing core: interframe timers, back-off, nav, tsf, sleep
// assumes controller strobes are one-cycle pulses synchronous to ref_clk_in
// Behaviour
// - interframe timers restart when the phy reports the medium has gone idle.
// - each access category engine decrements per idle slot, pauses when busy.
// - an engine reaching zero notifies the transmit engine.
// - simultaneous expiries grant exactly one, by controller priority policy.
// - sleep counter on slow rate gates the mac clock until expiry.
// - after waking, controller advances the sync timer by sleep time.
// - sync timer loads a received beacon timestamp on controller command.
// - beacon target time kept; pulse when the sync timer reaches it.
// - trigger pulses when sync timer reaches programmed offsets.
// - virtual busy timer loaded from duration fields, counts down.
// - nonzero virtual busy timer makes the medium count as busy.
// - channel-access status is reported for queue selection.
// - transmit starts only on the precise interframe start trigger.
// - triggers serve responses and bursts, short or reduced spacing.
`timescale 1ns/10ps
module cat_timing (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic phy_busy_in,
  input wire logic nav_load_in,
  input wire logic [cat_pkg::NAV_W-1:0] nav_dur_in,
  input wire logic tx_sched_in,
  input wire logic tx_use_rifs_in,
  input wire logic [cat_pkg::NUM_AC-1:0] bo_load_in,
  input wire logic [cat_pkg::BO_W-1:0] bo_load_val_in,
  input wire logic prio_policy_in,
  input wire logic tsf_load_in,
  input wire logic tsf_adv_in,
  input wire logic [cat_pkg::TSF_W-1:0] tsf_val_in,
  input wire logic beacon_target_time_load_in,
  input wire logic [cat_pkg::NUM_EVT-1:0] evt_load_in,
  input wire logic [cat_pkg::TSF_W-1:0] target_val_in,
  input wire logic sleep_go_in,
  input wire logic [cat_pkg::SLEEP_W-1:0] sleep_val_in,
  output logic medium_busy_out,
  output logic nav_busy_out,
  output logic sifs_trig_out,
  output logic rifs_trig_out,
  output logic tx_start_out,
  output logic [cat_pkg::NUM_AC-1:0] bo_zero_out,
  output logic [cat_pkg::NUM_AC-1:0] bo_grant_out,
  output logic [cat_pkg::TSF_W-1:0] tsf_out,
  output logic beacon_target_time_hit_out,
  output logic [cat_pkg::NUM_EVT-1:0] evt_trig_out,
  output logic mac_clk_en_out,
  output logic sleep_done_out
);
  localparam int NAC = cat_pkg::NUM_AC;
  localparam int CW = cat_pkg::CYC_W;
  localparam int TW = cat_pkg::TSF_W;

  // a target counts as reached only on the step that lands on it
  function automatic logic tsf_hit(input logic [TW-1:0] nxt,
                                   input logic [TW-1:0] cur,
                                   input logic [TW-1:0] tgt);
    tsf_hit = (nxt != cur) && (nxt == tgt);
  endfunction

  function automatic logic [NAC-1:0] pick_one(input logic [NAC-1:0] req,
                                              input logic low_first);
    logic [NAC-1:0] g;
    g = '0;
    for (int i = 0; i < NAC; i++) begin
      if (low_first) begin
        if (req[i] && g == '0) g[i] = 1'b1;
      end else if (req[NAC-1-i] && g == '0) begin
        g[NAC-1-i] = 1'b1;
      end
    end
    pick_one = g;
  endfunction

  cat_pkg::cat_slp_t slp_state_r, slp_state_nxt;
  logic [cat_pkg::SLEEP_W-1:0] slp_cnt_r, slp_cnt_nxt;
  logic [CW-1:0] slow_cnt_r, slow_cnt_nxt;
  logic slow_tick;
  logic mac_run;

  // sleep: slow rate keeps counting while the mac clock is gated off
  assign slow_tick = (slow_cnt_r == cat_pkg::SLOW_CNT - CW'(1));
  always_comb begin
    slow_cnt_nxt = slow_tick ? cat_pkg::CYC_RST : slow_cnt_r + CW'(1);
    slp_state_nxt = slp_state_r;
    slp_cnt_nxt = slp_cnt_r;
    unique case (slp_state_r)
      cat_pkg::SLP_AWAKE: begin
        if (sleep_go_in && sleep_val_in != '0) begin
          slp_cnt_nxt = sleep_val_in;
          slp_state_nxt = cat_pkg::SLP_ASLEEP;
        end
      end
      cat_pkg::SLP_ASLEEP: begin
        if (slow_tick) begin
          slp_cnt_nxt = slp_cnt_r - cat_pkg::SLEEP_W'(1);
          if (slp_cnt_r == cat_pkg::SLEEP_W'(1)) begin
            slp_state_nxt = cat_pkg::SLP_WAKE;
          end
        end
      end
      cat_pkg::SLP_WAKE: slp_state_nxt = cat_pkg::SLP_AWAKE;
      default: slp_state_nxt = cat_pkg::SLP_AWAKE;
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      slp_state_r <= cat_pkg::SLP_AWAKE;
      slp_cnt_r <= '0;
      slow_cnt_r <= cat_pkg::CYC_RST;
    end else begin
      slp_state_r <= slp_state_nxt;
      slp_cnt_r <= slp_cnt_nxt;
      slow_cnt_r <= slow_cnt_nxt;
    end
  end

  assign mac_run = (slp_state_r == cat_pkg::SLP_AWAKE);
  assign mac_clk_en_out = mac_run;
  assign sleep_done_out = (slp_state_r == cat_pkg::SLP_WAKE);

  // microsecond tick, nav and interframe/slot counters
  logic [CW-1:0] us_cnt_r, us_cnt_nxt, ifs_cnt_r, ifs_cnt_nxt;
  logic [CW-1:0] slot_cnt_r, slot_cnt_nxt;
  logic [cat_pkg::NAV_W-1:0] nav_r, nav_nxt;
  logic us_tick, busy, slot_tick;
  logic busy_r, sifs_r, rifs_r, tx_start_r;
  logic sifs_hit, rifs_hit;

  assign us_tick = mac_run && (us_cnt_r == cat_pkg::US_CNT - CW'(1));
  assign busy = phy_busy_in || (nav_r != '0);
  assign slot_tick = mac_run && !busy &&
                     (slot_cnt_r == cat_pkg::SLOT_CNT - CW'(1));
  assign sifs_hit = mac_run && !busy &&
                    (ifs_cnt_r == cat_pkg::SIFS_CNT - CW'(1));
  assign rifs_hit = mac_run && !busy &&
                    (ifs_cnt_r == cat_pkg::RIFS_CNT - CW'(1));

  always_comb begin
    us_cnt_nxt = us_cnt_r;
    nav_nxt = nav_r;
    ifs_cnt_nxt = ifs_cnt_r;
    slot_cnt_nxt = slot_cnt_r;
    if (mac_run) begin
      us_cnt_nxt = us_tick ? cat_pkg::CYC_RST : us_cnt_r + CW'(1);
      // a shorter duration never cuts an existing reservation
      if (nav_load_in && nav_dur_in > nav_r) begin
        nav_nxt = nav_dur_in;
      end else if (us_tick && nav_r != '0) begin
        nav_nxt = nav_r - cat_pkg::NAV_W'(1);
      end
      if (busy) begin
        ifs_cnt_nxt = cat_pkg::CYC_RST;
        slot_cnt_nxt = cat_pkg::CYC_RST;
      end else begin
        if (ifs_cnt_r != {CW{1'b1}}) ifs_cnt_nxt = ifs_cnt_r + CW'(1);
        slot_cnt_nxt = slot_tick ? cat_pkg::CYC_RST : slot_cnt_r + CW'(1);
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      us_cnt_r <= cat_pkg::CYC_RST;
      nav_r <= '0;
      ifs_cnt_r <= cat_pkg::CYC_RST;
      slot_cnt_r <= cat_pkg::CYC_RST;
      busy_r <= 1'b0;
      sifs_r <= 1'b0;
      rifs_r <= 1'b0;
      tx_start_r <= 1'b0;
    end else begin
      us_cnt_r <= us_cnt_nxt;
      nav_r <= nav_nxt;
      ifs_cnt_r <= ifs_cnt_nxt;
      slot_cnt_r <= slot_cnt_nxt;
      busy_r <= busy;
      sifs_r <= sifs_hit;
      rifs_r <= rifs_hit;
      // scheduled frame leaves only on the selected spacing trigger
      tx_start_r <= tx_sched_in &&
                    (tx_use_rifs_in ? rifs_hit : sifs_hit);
    end
  end

  assign medium_busy_out = busy_r;
  assign nav_busy_out = (nav_r != '0);
  assign sifs_trig_out = sifs_r;
  assign rifs_trig_out = rifs_r;
  assign tx_start_out = tx_start_r;

  // back-off engines, one per access category
  logic [NAC-1:0] done_w, grant_r, grant_nxt;
  for (genvar g = 0; g < NAC; g++) begin : g_ac
    cat_backoff u_bo (
      .ref_clk_in(ref_clk_in),
      .rst_in(rst_in),
      .run_in(mac_run),
      .load_in(bo_load_in[g]),
      .load_val_in(bo_load_val_in),
      .slot_tick_in(slot_tick),
      .busy_in(busy),
      .zero_out(bo_zero_out[g]),
      .done_out(done_w[g])
    );
  end

  // losers of a same-slot tie stay expired for the controller to retry
  always_comb begin
    grant_nxt = pick_one(done_w,
      prio_policy_in == cat_pkg::PRIO_LOW_FIRST);
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) grant_r <= '0;
    else grant_r <= grant_nxt;
  end
  assign bo_grant_out = grant_r;

  // sync timer, beacon target and offset events
  logic [TW-1:0] tsf_r, tsf_nxt, beacon_target_time_r, beacon_target_time_nxt;
  logic [TW-1:0] evt_r [cat_pkg::NUM_EVT];
  logic [TW-1:0] evt_nxt [cat_pkg::NUM_EVT];
  logic beacon_target_time_hit_r;
  logic [cat_pkg::NUM_EVT-1:0] evt_hit_r;

  always_comb begin
    tsf_nxt = tsf_r;
    beacon_target_time_nxt = beacon_target_time_r;
    evt_nxt = evt_r;
    if (mac_run) begin
      if (tsf_load_in) tsf_nxt = tsf_val_in;
      else if (tsf_adv_in) tsf_nxt = tsf_r + tsf_val_in;
      else if (us_tick) tsf_nxt = tsf_r + TW'(1);
      if (beacon_target_time_load_in) beacon_target_time_nxt = target_val_in;
      for (int i = 0; i < cat_pkg::NUM_EVT; i++) begin
        if (evt_load_in[i]) evt_nxt[i] = target_val_in;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      tsf_r <= cat_pkg::TSF_RST;
      beacon_target_time_r <= cat_pkg::TSF_RST;
      evt_r <= '{default: cat_pkg::TSF_RST};
      beacon_target_time_hit_r <= 1'b0;
      evt_hit_r <= '0;
    end else begin
      tsf_r <= tsf_nxt;
      beacon_target_time_r <= beacon_target_time_nxt;
      evt_r <= evt_nxt;
      beacon_target_time_hit_r <= tsf_hit(tsf_nxt, tsf_r, beacon_target_time_nxt);
      for (int i = 0; i < cat_pkg::NUM_EVT; i++) begin
        evt_hit_r[i] <= tsf_hit(tsf_nxt, tsf_r, evt_nxt[i]);
      end
    end
  end

  assign tsf_out = tsf_r;
  assign beacon_target_time_hit_out = beacon_target_time_hit_r;
  assign evt_trig_out = evt_hit_r;

  ifs_restart_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (mac_run && busy) |=> (ifs_cnt_r == '0 && !sifs_r))
    else $error("interframe timer did not restart on busy");
  nav_blocks_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (mac_run && nav_r != '0) |=> (slot_cnt_r == '0))
    else $error("slots counted during virtual busy");
  nav_load_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (mac_run && nav_load_in && nav_dur_in > nav_r) |=>
    (nav_r == $past(nav_dur_in)))
    else $error("virtual busy timer not loaded");
  grant_one_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (done_w != '0) |=> $onehot(grant_r))
    else $error("expiry tie not granted to exactly one");
  rifs_time_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    rifs_r |-> ($past(ifs_cnt_r) == cat_pkg::RIFS_CNT - CW'(1)))
    else $error("reduced spacing trigger at wrong count");
  tx_start_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    tx_start_r |-> ($past(tx_sched_in) && (sifs_r || rifs_r)))
    else $error("transmit start without scheduled trigger");
  tsf_load_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (mac_run && tsf_load_in) |=> (tsf_r == $past(tsf_val_in)))
    else $error("sync timer did not take timestamp");
  tsf_adv_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (mac_run && tsf_adv_in && !tsf_load_in) |=>
    (tsf_r == $past(tsf_r) + $past(tsf_val_in)))
    else $error("sync timer not advanced by sleep time");
  beacon_target_time_match_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    beacon_target_time_hit_r |-> (tsf_r == beacon_target_time_r))
    else $error("beacon target pulse off target");
  evt_match_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    evt_hit_r[0] |-> (tsf_r == evt_r[0]))
    else $error("offset trigger off target");
  sleep_wake_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (slp_state_r == cat_pkg::SLP_ASLEEP && slow_tick &&
     slp_cnt_r == cat_pkg::SLEEP_W'(1)) |=> (!mac_clk_en_out && sleep_done_out)
    ##1 mac_clk_en_out)
    else $error("sleep expiry did not restore the mac");
  reset_clear_a: assert property (@(posedge ref_clk_in)
    rst_in |=> (nav_r == '0 && ifs_cnt_r == '0 && slp_cnt_r == '0 &&
                !tx_start_r && !sifs_r && !rifs_r && grant_r == '0))
    else $error("reset left a counter or trigger set");
endmodule // cat_timing

/* File: tb/cat_phy_model.sv */
// partner model: phy channel-activity indication on request
// assumes the bench pulses go_in for one cycle with the length in len_in
`timescale 1ns/10ps
module cat_phy_model (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic go_in,
  input wire logic [15:0] len_in,
  output logic busy_out
);
  logic [15:0] left_r;
  logic [15:0] left_nxt;
  // carrier stays high for len_in cycles, then the medium goes quiet
  always_comb begin
    left_nxt = left_r;
    if (go_in) begin
      left_nxt = len_in;
    end else if (left_r != 16'h0000) begin
      left_nxt = left_r - 16'h0001;
    end
  end
  always_ff @(posedge ref_clk_in) begin
    left_r <= rst_in ? 16'h0000 : left_nxt;
  end
  assign busy_out = (left_r != 16'h0000);
endmodule // cat_phy_model

/* File: tb/cat_timing_bench.sv */
// self-checking bench for the channel-access timing core
// assumes cat_phy_model drives the medium; the bench plays the controller
`timescale 1ns/10ps
module cat_timing_bench;
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic go = 1'b0, nav_ld = 1'b0, sched = 1'b0, use_rifs = 1'b0;
  logic prio = 1'b0, tsf_ld = 1'b0, tsf_adv = 1'b0, beacon_target_time_ld = 1'b0;
  logic sleep_go = 1'b0;
  logic [15:0] len = 16'h0000, nav_dur = 16'h0000;
  logic [3:0] bo_ld = 4'h0;
  logic [9:0] bo_val = 10'h000;
  logic [1:0] evt_ld = 2'h0;
  logic [63:0] tsf_val = 64'h0, tgt = 64'h0, sync_timer, saved;
  logic [31:0] sleep_val = 32'h0;
  logic phy_busy, med_busy, nav_busy, sifs, rifs, tx_start, beacon_target_time;
  logic clk_en, sleep_done;
  logic [3:0] bo_zero, grant;
  logic [1:0] evt;
  int errors = 0;
  int checked = 0;
  int n;
  cat_phy_model u_phy (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .go_in(go), .len_in(len), .busy_out(phy_busy));
  cat_timing u_dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .phy_busy_in(phy_busy), .nav_load_in(nav_ld), .nav_dur_in(nav_dur),
    .tx_sched_in(sched), .tx_use_rifs_in(use_rifs), .bo_load_in(bo_ld),
    .bo_load_val_in(bo_val), .prio_policy_in(prio), .tsf_load_in(tsf_ld),
    .tsf_adv_in(tsf_adv), .tsf_val_in(tsf_val), .beacon_target_time_load_in(beacon_target_time_ld),
    .evt_load_in(evt_ld), .target_val_in(tgt), .sleep_go_in(sleep_go),
    .sleep_val_in(sleep_val), .medium_busy_out(med_busy),
    .nav_busy_out(nav_busy), .sifs_trig_out(sifs), .rifs_trig_out(rifs),
    .tx_start_out(tx_start), .bo_zero_out(bo_zero), .bo_grant_out(grant),
    .tsf_out(sync_timer), .beacon_target_time_hit_out(beacon_target_time), .evt_trig_out(evt),
    .mac_clk_en_out(clk_en), .sleep_done_out(sleep_done));
  // free-running 100 MHz clock
  initial begin
    forever #5 ref_clk_in = ~ref_clk_in;
  end
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk_val(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_rng(input int got, input int lo, input int hi);
    checked++;
    if (got < lo || got > hi) begin
      errors++;
      $display("wrong value at %0t got %h exp %h..%h", $time, got, lo, hi);
    end
  endtask
  // bounded wait; a wait that runs out ends the run
  task automatic wait_on(input int sel, input int lim, output int cnt);
    logic s;
    cnt = 0;
    s = 1'b0;
    while (s !== 1'b1) begin
      @(posedge ref_clk_in);
      #1;
      cnt++;
      case (sel)
        0: s = rifs;
        1: s = sifs;
        2: s = beacon_target_time;
        3: s = &evt;
        4: s = |grant;
        5: s = sleep_done;
        6: s = ~nav_busy;
        default: s = ~phy_busy;
      endcase
      if (cnt > lim) begin
        errors++;
        $display("wait %0d ran out at %0t", sel, $time);
        final_report();
      end
    end
  endtask
  task automatic burst(input logic [15:0] l);
    @(posedge ref_clk_in);
    go <= 1'b1;
    len <= l;
    @(posedge ref_clk_in);
    go <= 1'b0;
    wait_on(7, 70000, n);
  endtask
  task automatic t_ifs;
    sched <= 1'b1;
    use_rifs <= 1'b1;
    burst(16'd50);
    wait_on(0, 1100, n);
    chk_rng(n, 200, 200);
    chk_val(tx_start, 1'b1);
    wait_on(1, 1100, n);
    chk_rng(n, 800, 800);
    @(posedge ref_clk_in);
    use_rifs <= 1'b0;
    burst(16'd50);
    wait_on(1, 1100, n);
    chk_rng(n, 1000, 1000);
    chk_val(tx_start, 1'b1);
    @(posedge ref_clk_in);
    sched <= 1'b0;
    $display("interframe test done");
  endtask
  task automatic t_nav;
    @(posedge ref_clk_in);
    nav_ld <= 1'b1;
    nav_dur <= 16'd3;
    @(posedge ref_clk_in);
    nav_ld <= 1'b0;
    @(posedge ref_clk_in);
    #1;
    chk_val(nav_busy, 1'b1);
    chk_val(med_busy, 1'b1);
    wait_on(6, 400, n);
    chk_rng(n, 198, 301);
    $display("virtual busy test done");
  endtask
  task automatic t_backoff(input logic p, input logic [3:0] m,
                           input logic [3:0] exp, input logic [15:0] hold);
    @(posedge ref_clk_in);
    prio <= p;
    bo_ld <= m;
    bo_val <= 10'd1;
    go <= 1'b1;
    len <= hold;
    @(posedge ref_clk_in);
    bo_ld <= 4'h0;
    go <= 1'b0;
    wait_on(7, 70000, n);
    chk_val(bo_zero & m, 4'h0);
    chk_val(grant, 4'h0);
    wait_on(4, 1000, n);
    chk_val(grant, exp);
    chk_val(bo_zero & m, m);
    @(posedge ref_clk_in);
    #1;
    chk_val(grant, 4'h0);
    $display("back-off test done");
  endtask
  task automatic t_sync;
    @(posedge ref_clk_in);
    tsf_ld <= 1'b1;
    tsf_val <= 64'h0000_0001_0000_00fe;
    beacon_target_time_ld <= 1'b1;
    evt_ld <= 2'h3;
    tgt <= 64'h0000_0001_0000_00ff;
    @(posedge ref_clk_in);
    {tsf_ld, beacon_target_time_ld, evt_ld} <= 4'h0;
    #1;
    chk_val(sync_timer, 64'h0000_0001_0000_00fe);
    wait_on(2, 250, n);
    chk_val(sync_timer, 64'h0000_0001_0000_00ff);
    chk_val(evt, 2'h3);
    $display("sync timer test done");
  endtask
  task automatic t_sleep;
    @(posedge ref_clk_in);
    sleep_go <= 1'b1;
    sleep_val <= 32'h0000_0002;
    @(posedge ref_clk_in);
    sleep_go <= 1'b0;
    #1;
    saved = sync_timer;
    chk_val(clk_en, 1'b0);
    wait_on(5, 6200, n);
    chk_rng(n, 3051, 6106);
    chk_val(clk_en, 1'b0);
    chk_val(sync_timer, saved);
    // advance is driven on the waking edge, taken once the mac runs
    @(posedge ref_clk_in);
    tsf_adv <= 1'b1;
    tsf_val <= 64'h0000_0000_0000_003d;
    #1;
    chk_val(clk_en, 1'b1);
    @(posedge ref_clk_in);
    tsf_adv <= 1'b0;
    #1;
    chk_val(sync_timer, saved + 64'h3d);
    $display("sleep test done");
  endtask
  // main sequence
  initial begin
    repeat (11) @(posedge ref_clk_in);
    #1;
    chk_val({sifs, rifs, tx_start, beacon_target_time, evt, grant}, 10'h000);
    chk_val({sync_timer, bo_zero, nav_busy, clk_en}, {64'h0, 4'hf, 2'b01});
    @(posedge ref_clk_in);
    rst_in <= 1'b0;
    t_ifs();
    t_nav();
    t_backoff(1'b0, 4'b0101, 4'b0100, 16'd3000);
    t_backoff(1'b1, 4'b0110, 4'b0010, 16'd100);
    t_sync();
    t_sleep();
    final_report();
  end
endmodule // cat_timing_bench
